/* qsd_debug.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1 - Rising E phase reports queue data movement
// RL2 - Falling E phase reports execution start
// RL3 - Movement code describes previous falling-edge bus data
// RL4 - Start code describes cycle beginning that edge
// RL5 - Tracer samples movement rising, start falling
// RL6 - Two 16-bit stages plus holding latch
// RL7 - Advance shifts stage one, reloads it
// RL8 - Even starts high byte, odd low
// RL9 - Three program bytes ready at start
// RL10 - Instruction completes before next one begins
// RL11 - Hardware commands use free or stolen cycles
// RL12 - Firmware commands only in active background
// RL13 - Debug ROM mapped only while active
// RL14 - Host talks over single debug wire
// RL15 - Available always, must be activated first
// RL16 - Byte write to FF01 sets enable
// RL17 - Activation maps FF00-FFFF, enters background
// RL18 - Halt, tag, or enter instruction activates
// RL19 - Activation without enable resumes after delay
// RL20 - Halt activates at next instruction boundary
// RL21 - Tag activates before tagged instruction runs
// RL22 - Host falling edge starts bit, MSB first
// RL23 - Freeze CPU after 128 cycles without bus
// RL24 - Opcode 90 halts only when enabled
// RL25 - Opcode C4, address, data; odd low byte
// RL26 - Reset shows 0:0 on status pins
module qsd_debug
  import qsd_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int REJECT_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Bus phase and processor queue activity
  input wire logic bus_phase_clock,
  input wire logic [1:0] cpu_move_code,
  input wire logic cpu_move_valid,
  input wire logic [1:0] cpu_start_code,
  input wire logic [WIDTH-1:0] bus_data,
  input wire logic bus_free,
  input wire logic instr_boundary,
  input wire logic tag_hit,
  input wire logic enter_debug_instruction,
  // Debug bit clock enable
  input wire logic debug_bit_clock,
  // Debug wire, three-signal form
  input wire logic debug_wire_in,
  output logic debug_wire_out,
  output logic debug_wire_oe_n,
  // Trace and debug outputs
  output logic [1:0] queue_status_pins,
  output logic [7:0] exec_opcode,
  output logic exec_ready,
  output logic background_debug_state,
  output logic debug_map_visible,
  output logic cpu_freeze,
  output logic firmware_enable_bit,
  output qsd_write_s mem_write,
  output logic [WIDTH-1:0] stage1,
  output logic [WIDTH-1:0] stage2
);
`include "qsd_consts.svh"

  function automatic logic in_debug_map(input logic [15:0] a);
    in_debug_map = (a >= `QSD_MAP_BASE) && (a <= `QSD_MAP_LAST);
  endfunction

  qsd_status_s status_reg;
  logic phase_d_reg;
  logic [WIDTH-1:0] hold_latch;
  logic [2:0] bytes_ready_reg;
  logic [15:0] pending_ir_reg;

  // Movement code is captured from the previous low phase so the tracer
  // sees the bus data of the preceding falling edge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= '0; // RL26
      phase_d_reg <= 1'b0;
    end else if (clk_en) begin
      phase_d_reg <= bus_phase_clock;
      if (!bus_phase_clock) begin
        status_reg.move_code <= cpu_move_valid ? cpu_move_code
                                               : `QSD_MOVE_NONE; // RL3
        status_reg.start_code <= cpu_start_code; // RL4
      end
    end
  end

  // High phase shows movement, low phase shows start; RL5 samples each
  always_comb begin
    if (!reset_n)
      queue_status_pins = `QSD_MOVE_NONE; // RL26
    else if (bus_phase_clock)
      queue_status_pins = status_reg.move_code; // RL1
    else
      queue_status_pins = cpu_start_code; // RL2
  end

  qsd_queue_mem #(.WIDTH(WIDTH)) u_queue (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .move_code(cpu_move_code),
    .move_valid(cpu_move_valid && !phase_d_reg && bus_phase_clock),
    .bus_data(bus_data),
    .stage1(stage1), // RL6
    .stage2(stage2),
    .hold_latch(hold_latch)
  );

  // Byte accounting: a start is honoured only with at least three bytes queued
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bytes_ready_reg <= 3'h0;
      exec_opcode <= 8'h00;
      exec_ready <= 1'b0;
    end else if (clk_en) begin
      exec_ready <= 1'b0;
      if (cpu_move_valid && !phase_d_reg && bus_phase_clock &&
          cpu_move_code != `QSD_MOVE_LATCH &&
          cpu_move_code != `QSD_MOVE_NONE && bytes_ready_reg < 3'h4)
        bytes_ready_reg <= bytes_ready_reg + 3'h2;
      if (phase_d_reg && !bus_phase_clock && bytes_ready_reg >= 3'h3) begin
        // RL9 RL10
        if (cpu_start_code == `QSD_START_EVEN) begin
          exec_opcode <= stage2[15:8]; // RL8
          exec_ready <= 1'b1;
        end else if (cpu_start_code == `QSD_START_ODD) begin
          exec_opcode <= stage2[7:0]; // RL8
          exec_ready <= 1'b1;
        end
      end
    end
  end

  // Serial receiver on the debug wire; the device never drives while
  // the host transmits, so the pin stays released here.
  qsd_cmd_e cmd_reg;
  logic wire_d_reg;
  logic [4:0] bit_cnt_reg;
  logic [3:0] cyc_cnt_reg;
  logic [9:0] idle_cnt_reg;
  logic [15:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [15:0] addr_reg;
  logic [7:0] steal_cnt_reg;
  logic in_bit_reg;
  logic halt_pending_reg;
  logic activate_req;
  logic [3:0] reject_cnt_reg;
  logic got_bit;

  assign debug_wire_out = 1'b1;
  assign debug_wire_oe_n = 1'b1; // RL14
  assign got_bit = debug_bit_clock && in_bit_reg &&
                   cyc_cnt_reg == 4'(`QSD_SAMPLE_CYCLE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wire_d_reg <= 1'b1;
      in_bit_reg <= 1'b0;
      cyc_cnt_reg <= 4'h0;
      idle_cnt_reg <= 10'h000;
    end else if (clk_en) begin
      wire_d_reg <= debug_wire_in;
      if (wire_d_reg && !debug_wire_in) begin
        in_bit_reg <= 1'b1; // RL22
        cyc_cnt_reg <= 4'h0;
        idle_cnt_reg <= 10'h000;
      end else if (debug_bit_clock) begin
        if (in_bit_reg)
          cyc_cnt_reg <= cyc_cnt_reg + 4'h1;
        if (in_bit_reg && cyc_cnt_reg == 4'(`QSD_BIT_CYCLES - 1))
          in_bit_reg <= 1'b0;
        if (idle_cnt_reg != 10'(`QSD_TIMEOUT_CYCLES))
          idle_cnt_reg <= idle_cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= QSD_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      opcode_reg <= 8'h00;
      addr_reg <= 16'h0000;
      steal_cnt_reg <= 8'h00;
      mem_write <= '0;
      halt_pending_reg <= 1'b0;
    end else if (clk_en) begin
      mem_write.valid <= 1'b0;
      if (halt_pending_reg && activate_req)
        halt_pending_reg <= 1'b0;
      if (idle_cnt_reg == 10'(`QSD_TIMEOUT_CYCLES) && cmd_reg != QSD_WAIT_BUS)
        cmd_reg <= QSD_IDLE;
      else
        case (cmd_reg)
          QSD_IDLE: if (got_bit) begin
            shift_reg <= {15'h0000, debug_wire_in};
            bit_cnt_reg <= 5'h01;
            cmd_reg <= QSD_OPCODE;
          end
          QSD_OPCODE: if (got_bit) begin
            shift_reg <= {shift_reg[14:0], debug_wire_in}; // RL22
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'h07) begin
              opcode_reg <= {shift_reg[6:0], debug_wire_in};
              bit_cnt_reg <= 5'h00;
              if ({shift_reg[6:0], debug_wire_in} == `QSD_OP_HALT) begin
                halt_pending_reg <= 1'b1; // RL24
                cmd_reg <= QSD_IDLE;
              end else if ({shift_reg[6:0], debug_wire_in} ==
                           `QSD_OP_BD_WRITE_BYTE)
                cmd_reg <= QSD_ADDR; // RL25
              else
                cmd_reg <= QSD_IDLE;
            end
          end
          QSD_ADDR: if (got_bit) begin
            shift_reg <= {shift_reg[14:0], debug_wire_in};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(`QSD_WORD_BITS - 1)) begin
              addr_reg <= {shift_reg[14:0], debug_wire_in};
              bit_cnt_reg <= 5'h00;
              cmd_reg <= QSD_DATA;
            end
          end
          QSD_DATA: if (got_bit) begin
            shift_reg <= {shift_reg[14:0], debug_wire_in};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(`QSD_WORD_BITS - 1)) begin
              bit_cnt_reg <= 5'h00;
              steal_cnt_reg <= 8'h00;
              cmd_reg <= QSD_WAIT_BUS;
            end
          end
          QSD_WAIT_BUS: begin
            if (bus_free || cpu_freeze) begin // RL11
              mem_write.valid <= 1'b1;
              mem_write.addr <= addr_reg;
              mem_write.high_byte <= !addr_reg[0];
              mem_write.data <= shift_reg; // RL25
              cmd_reg <= QSD_IDLE;
            end else if (debug_bit_clock &&
                         steal_cnt_reg != 8'(`QSD_STEAL_CYCLES))
              steal_cnt_reg <= steal_cnt_reg + 8'h01;
          end
          default: cmd_reg <= QSD_IDLE;
        endcase
    end
  end

  // Freeze after the wait for a free cycle has run out, and for a short
  // spell after a refused activation so the processor resumes cleanly
  assign cpu_freeze = (cmd_reg == QSD_WAIT_BUS &&
                       steal_cnt_reg == 8'(`QSD_STEAL_CYCLES)) || // RL23
                      reject_cnt_reg != 4'h0; // RL19

  // Enable bit, written through the status address in the debug map
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      firmware_enable_bit <= 1'b0;
    else if (clk_en && mem_write.valid &&
             mem_write.addr == `QSD_STATUS_ADDR)
      firmware_enable_bit <=
        mem_write.data[`QSD_FW_ENABLE_BIT]; // RL16
  end

  // Halt waits for a boundary; tags act before the tagged opcode runs
  assign activate_req = (halt_pending_reg && instr_boundary) || // RL20
                        tag_hit || // RL21
                        enter_debug_instruction; // RL18

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      background_debug_state <= 1'b0;
      reject_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      if (reject_cnt_reg != 4'h0)
        reject_cnt_reg <= reject_cnt_reg - 4'h1;
      if (activate_req && !background_debug_state) begin
        if (firmware_enable_bit)
          background_debug_state <= 1'b1; // RL15 RL17
        else
          reject_cnt_reg <= 4'(REJECT_CYCLES); // RL19
      end
    end
  end

  // Debug map exists only in active background
  assign debug_map_visible = background_debug_state &&
                             in_debug_map(`QSD_MAP_BASE); // RL12 RL13
endmodule
`default_nettype wire

/* qsd_consts.svh */
`ifndef QSD_CONSTS_SVH
`define QSD_CONSTS_SVH

// Queue status codes, data-movement phase
`define QSD_MOVE_NONE 2'h0
`define QSD_MOVE_LATCH 2'h1
`define QSD_MOVE_ADV_BUS 2'h2
`define QSD_MOVE_ADV_LATCH 2'h3
// Queue status codes, execution-start phase
`define QSD_START_NONE 2'h0
`define QSD_START_INT 2'h1
`define QSD_START_EVEN 2'h2
`define QSD_START_ODD 2'h3

// Serial command opcodes
`define QSD_OP_HALT 8'h90
`define QSD_OP_BD_WRITE_BYTE 8'hC4

// Debug map
`define QSD_STATUS_ADDR 16'hFF01
`define QSD_MAP_BASE 16'hFF00
`define QSD_MAP_LAST 16'hFFFF
`define QSD_FW_ENABLE_BIT 7

// Serial timing in debug clock cycles
`define QSD_BIT_CYCLES 16
`define QSD_SAMPLE_CYCLE 10
`define QSD_TIMEOUT_CYCLES 512
`define QSD_STEAL_CYCLES 128
`define QSD_REJECT_CYCLES 4
`define QSD_WORD_BITS 16

`endif

/* qsd_pkg.sv */
package qsd_pkg;
  typedef enum logic [2:0] {
    QSD_IDLE, QSD_OPCODE, QSD_ADDR, QSD_DATA, QSD_WAIT_BUS
  } qsd_cmd_e;

  typedef struct packed {
    logic [1:0] move_code;
    logic [1:0] start_code;
  } qsd_status_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
    logic high_byte;
  } qsd_write_s;
endpackage

/* qsd_queue_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Two 16-bit queue stages and the holding latch in front of them
module qsd_queue_mem #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic [1:0] move_code,
  input wire logic move_valid,
  input wire logic [WIDTH-1:0] bus_data,
  // Stage contents
  output logic [WIDTH-1:0] stage1,
  output logic [WIDTH-1:0] stage2,
  output logic [WIDTH-1:0] hold_latch
);
`include "qsd_consts.svh"

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      hold_latch <= '0;
    end else if (clk_en && move_valid) begin
      case (move_code)
        `QSD_MOVE_LATCH: hold_latch <= bus_data;
        `QSD_MOVE_ADV_BUS: begin
          stage2 <= stage1; // RL7
          stage1 <= bus_data; // RL7
        end
        `QSD_MOVE_ADV_LATCH: begin
          stage2 <= stage1; // RL7
          stage1 <= hold_latch; // RL7
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* qsd_debug_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module qsd_debug_monitor
  import qsd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Stimulus seen
  input wire logic bus_phase_clock,
  input wire logic [1:0] cpu_move_code,
  input wire logic cpu_move_valid,
  input wire logic [1:0] cpu_start_code,
  input wire logic bus_free,
  input wire logic instr_boundary,
  input wire logic tag_hit,
  input wire logic enter_debug_instruction,
  // Outputs watched
  input wire logic debug_wire_oe_n,
  input wire logic [1:0] queue_status_pins,
  input wire logic background_debug_state,
  input wire logic debug_map_visible,
  input wire logic cpu_freeze,
  input wire logic firmware_enable_bit,
  input wire qsd_write_s mem_write
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_reset_status: assert property (disable iff (1'b0)
    !reset_n |-> queue_status_pins == 2'h0)
    else $error("status pins not idle in reset");
  chk_start_pass: assert property (
    !bus_phase_clock |-> queue_status_pins == cpu_start_code)
    else $error("start code not shown in low phase");
  chk_move_code: assert property (
    $rose(bus_phase_clock) && $past(cpu_move_valid)
      |-> queue_status_pins == $past(cpu_move_code))
    else $error("movement code wrong at high phase");
  chk_move_hold: assert property (
    bus_phase_clock && $past(bus_phase_clock) |-> $stable(queue_status_pins))
    else $error("movement code moved in high phase");
  chk_map_follow: assert property (
    debug_map_visible == background_debug_state)
    else $error("debug map differs from background state");
  chk_bg_enable: assert property (
    $rose(background_debug_state) |-> firmware_enable_bit)
    else $error("background entered without enable");
  chk_bg_cause: assert property (
    $rose(background_debug_state)
      |-> $past(instr_boundary || tag_hit || enter_debug_instruction))
    else $error("background entered without a cause");
  chk_enable_write: assert property (
    $rose(firmware_enable_bit) |-> $past(mem_write.valid)
      && $past(mem_write.addr) == 16'hFF01)
    else $error("enable set without status write");
  chk_write_lane: assert property (
    mem_write.valid |-> mem_write.high_byte == !mem_write.addr[0])
    else $error("byte lane wrong for address");
  chk_write_slot: assert property (
    $rose(mem_write.valid) |-> $past(bus_free) || $past(cpu_freeze))
    else $error("write without free or stolen cycle");
  chk_wire_free: assert property (debug_wire_oe_n)
    else $error("debug wire driven by device");
endmodule
`default_nettype wire

/* qsd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qsd_host_model (
  // Clock
  input wire logic clock,
  // Host side of the debug wire, high when released
  output var logic wire_level
);
  initial wire_level = 1'b1;
  // Called just after a falling clock edge; one bit spans 16 ticks
  task automatic send_bit(input logic b);
    wire_level = 1'b0;
    repeat (2) @(negedge clock);
    wire_level = b;
    repeat (11) @(negedge clock);
    wire_level = 1'b1;
    repeat (3) @(negedge clock);
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask
  task automatic send_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) send_bit(v[i]);
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qsd_pkg::*;
  logic clock, reset_n, bus_phase_clock, cpu_move_valid;
  logic bus_free, instr_boundary, host_level;
  logic clk_en, tag_hit, enter_debug_instruction;
  logic [1:0] cpu_move_code, cpu_start_code, queue_status_pins;
  logic [15:0] bus_data, stage1, stage2;
  logic debug_wire_out, debug_wire_oe_n, exec_ready, background_debug_state;
  logic debug_map_visible, cpu_freeze, firmware_enable_bit;
  logic [7:0] exec_opcode;
  wire logic debug_wire_in;
  qsd_write_s mem_write;
  int fails, samples_checked;
  // Pseudo-open-drain: either party pulls low
  assign debug_wire_in = host_level & (debug_wire_oe_n | debug_wire_out);

  qsd_debug u_dut (.clock, .reset_n, .clk_en, .bus_phase_clock,
    .cpu_move_code, .cpu_move_valid, .cpu_start_code, .bus_data,
    .bus_free, .instr_boundary, .tag_hit,
    .enter_debug_instruction, .debug_bit_clock(1'b1),
    .debug_wire_in, .debug_wire_out, .debug_wire_oe_n, .queue_status_pins,
    .exec_opcode, .exec_ready, .background_debug_state, .debug_map_visible,
    .cpu_freeze, .firmware_enable_bit, .mem_write, .stage1, .stage2);
  qsd_host_model u_host (.clock, .wire_level(host_level));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checked=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic pulse_boundary;
    instr_boundary = 1'b1;
    @(negedge clock);
    instr_boundary = 1'b0;
  endtask

  task automatic pulse_cause(input logic use_tag);
    tag_hit = use_tag;
    enter_debug_instruction = !use_tag;
    @(negedge clock);
    tag_hit = 1'b0;
    enter_debug_instruction = 1'b0;
  endtask

  task automatic test_status;
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      bus_phase_clock = 1'b0;
      cpu_move_code = 2'(k);
      cpu_start_code = 2'(3 - k);
      bus_data = 16'(k);
      @(negedge clock);
      check(queue_status_pins, 16'(3 - k));
      bus_phase_clock = 1'b1;
      @(negedge clock);
      check(queue_status_pins, 16'(k));
      @(negedge clock);
      check(queue_status_pins, 16'(k));
    end
    check(stage1, 16'h0001);
    check(stage2, 16'h0002);
    // Odd start once four bytes are queued runs the low byte of stage two
    bus_phase_clock = 1'b0;
    cpu_start_code = 2'h3;
    @(negedge clock);
    check(exec_ready, 16'h1);
    check(exec_opcode, 16'h0002);
    cpu_start_code = 2'h0;
    $display("status test done");
  endtask

  task automatic test_halt(input logic exp);
    u_host.send_byte(8'h90);
    pulse_boundary();
    check(cpu_freeze, 16'(!exp));
    repeat (4) @(negedge clock);
    check(cpu_freeze, 16'h0);
    check(background_debug_state, 16'(exp));
    check(debug_map_visible, 16'(exp));
    $display("halt test done");
  endtask

  task automatic test_enable;
    bit saw;
    saw = 1'b0;
    u_host.send_byte(8'hC4);
    u_host.send_word(16'hFF01);
    u_host.send_word(16'h0080);
    // No free cycle for a while, so the steal path must kick in
    for (int i = 0; i < 300 && mem_write.valid !== 1'b1; i++) begin
      @(negedge clock);
      if (cpu_freeze === 1'b1) saw = 1'b1;
      if (i == 150) bus_free = 1'b1;
    end
    check(saw, 16'h1);
    check(mem_write.valid, 16'h1);
    check(mem_write.addr, 16'hFF01);
    check(mem_write.data, 16'h0080);
    check(mem_write.high_byte, 16'h0);
    @(negedge clock);
    bus_free = 1'b0;
    @(negedge clock);
    check(firmware_enable_bit, 16'h1);
    $display("enable test done");
  endtask

  // Mid-run reset, refused entry, enable over a free cycle, then entry
  task automatic test_entry(input logic use_tag);
    reset_n = 1'b0;
    cpu_start_code = 2'h3;
    repeat (2) @(negedge clock);
    check(queue_status_pins, 16'h0);
    check(firmware_enable_bit, 16'h0);
    check(background_debug_state, 16'h0);
    reset_n = 1'b1;
    cpu_start_code = 2'h0;
    pulse_cause(use_tag);
    check(cpu_freeze, 16'h1);
    repeat (4) @(negedge clock);
    check(cpu_freeze, 16'h0);
    check(background_debug_state, 16'h0);
    bus_free = 1'b1;
    u_host.send_byte(8'hC4);
    u_host.send_word(16'hFF01);
    u_host.send_word(16'h0080);
    repeat (2) @(negedge clock);
    bus_free = 1'b0;
    check(firmware_enable_bit, 16'h1);
    // A frozen block must ignore the cause entirely
    clk_en = 1'b0;
    pulse_cause(use_tag);
    @(negedge clock);
    check(background_debug_state, 16'h0);
    clk_en = 1'b1;
    pulse_cause(use_tag);
    @(negedge clock);
    check(background_debug_state, 16'h1);
    check(debug_map_visible, 16'h1);
    $display("entry test done");
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    bus_phase_clock = 1'b1;
    cpu_move_code = 2'h0;
    cpu_move_valid = 1'b1;
    cpu_start_code = 2'h0;
    bus_data = 16'h0000;
    bus_free = 1'b0;
    instr_boundary = 1'b0;
    clk_en = 1'b1;
    tag_hit = 1'b0;
    enter_debug_instruction = 1'b0;
    repeat (3) @(negedge clock);
    check(queue_status_pins, 16'h0);
    reset_n = 1'b1;
    bus_phase_clock = 1'b0;
    test_status();
    test_halt(1'b0);
    test_enable();
    test_halt(1'b1);
    test_entry(1'b1);
    test_entry(1'b0);
    summarize();
  end

  // Whole run is near 2500 cycles; allow about four times that
  initial begin
    #250000;
    fails++;
    summarize();
  end
endmodule

bind qsd_debug qsd_debug_monitor u_mon (.clock, .reset_n, .bus_phase_clock,
  .cpu_move_code, .cpu_move_valid, .cpu_start_code, .bus_free,
  .instr_boundary, .tag_hit, .enter_debug_instruction, .debug_wire_oe_n,
  .queue_status_pins, .background_debug_state, .debug_map_visible,
  .cpu_freeze, .firmware_enable_bit, .mem_write);
`default_nettype wire
